/* File: include/etc_pkg.sv */
// constants for the external trigger controller
// assumes a 10 MHz system clock and AHB-Lite register access
package etc_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned WIDTH_UNIT_US   = 100;
    localparam int unsigned UNIT_CYC        = (CLK_HZ / 1_000_000) * WIDTH_UNIT_US;
    localparam int unsigned WIDTH_MIN_UNITS = 1;
    localparam int unsigned WIDTH_MAX_UNITS = 1000;
    localparam int unsigned TRANS_DELAY_MS  = 100;
    localparam int unsigned TRANS_DELAY_CYC = (CLK_HZ / 1000) * TRANS_DELAY_MS;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_TRIGV  = 8'h04;
    localparam logic [7:0] REG_TRIGF  = 8'h08;
    localparam logic [7:0] REG_WIDTH  = 8'h0c;
    localparam logic [7:0] REG_CMD    = 8'h10;
    localparam logic [7:0] REG_SETV   = 8'h14;
    localparam logic [7:0] REG_SETF   = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1c;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTRL_IN_AUTO  = 0;
    localparam int CTRL_ACT_LSB  = 1;
    localparam int CTRL_SLOT_LSB = 4;
    localparam int CTRL_OUT_AUTO = 8;
    localparam int CTRL_SRC_LSB  = 9;
    localparam int CTRL_TEST_RUN = 12;

    // command register bits (write one to act, except the power value bit and the slot index field)
    localparam int CMD_SW_TRIG = 0;
    localparam int CMD_SAVE    = 1;
    localparam int CMD_LOAD    = 2;
    localparam int CMD_CLEAR   = 3;
    localparam int CMD_PWR     = 4;
    localparam int CMD_PWR_VAL = 5;
    localparam int CMD_SLOT_LSB = 8;

    // status fields
    localparam int STAT_PWR     = 0;
    localparam int STAT_TRIGOUT = 1;
    localparam int STAT_TRANS   = 2;
    localparam int STAT_VALID_LSB = 16;

    localparam logic [15:0] FSET_MIN_RESET = 16'h1194;
    localparam int unsigned NUM_SLOTS = 10;

    typedef enum logic [2:0] {
        ETC_ACT_NONE, ETC_ACT_OUTPUT, ETC_ACT_SETTING, ETC_ACT_PRESET, ETC_ACT_TRANS
    } etc_action_e;

    typedef enum logic [2:0] {
        ETC_SRC_NONE, ETC_SRC_OUTPUT, ETC_SRC_SETTING, ETC_SRC_PRESET, ETC_SRC_ALL
    } etc_source_e;

endpackage

/* File: verification/etc_equip.sv */
// test equipment on the rear signal connector
// drives trig_in and times each trig_out pulse in clk_sys cycles
`timescale 1ns/1ns
`default_nettype none
module etc_equip (
    input  wire logic clk_sys,
    input  wire logic trig_out,
    output logic      trig_in,
    output int        n_pulses,
    output int        last_width
);
    int run_q;
    initial begin
        trig_in = 1'b0;
        n_pulses = 0;
        last_width = 0;
        run_q = 0;
    end
    // high for n cycles, then a low gap
    task automatic strike(input int n);
        @(posedge clk_sys);
        trig_in <= 1'b1;
        repeat (n) @(posedge clk_sys);
        trig_in <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask
    always @(posedge clk_sys) begin
        if (trig_out === 1'b1) begin
            run_q <= run_q + 1;
        end else if (run_q != 0) begin
            n_pulses <= n_pulses + 1;
            last_width <= run_q;
            run_q <= 0;
        end
    end
endmodule // etc_equip
`default_nettype wire

/* File: verification/etc_monitor.sv */
// port checker for etc_top
// assumes hready is tied to hreadyout
`timescale 1ns/1ns
`default_nettype none
module etc_monitor
    import etc_pkg::*;
#(
    parameter int unsigned DELAY_CYC      = TRANS_DELAY_CYC,
    parameter int unsigned PULSE_UNIT_CYC = UNIT_CYC
) (
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        trig_in,
    input wire logic        trig_out,
    input wire logic        power_on,
    input wire logic [15:0] volt_set,
    input wire logic [15:0] freq_set,
    input wire logic        transient_start
);
    localparam int D_LO = DELAY_CYC - 1;
    localparam int D_HI = DELAY_CYC + 4;
    logic        wr_q;
    logic [7:0]  wa_q;
    logic [12:0] ctrl_q;
    logic [15:0] trigv_q;
    logic [15:0] trigf_q;
    int unsigned wid_q;
    int unsigned hi_q;
    logic        fire;
    logic        run;
    logic [2:0]  act;
    logic [2:0]  src;
    logic        pwr_q;
    logic        pwr_src;
    assign act = ctrl_q[3:1];
    assign src = ctrl_q[11:9];
    assign run = ctrl_q[CTRL_TEST_RUN];
    // remote trigger only counts in manual input mode
    assign fire = wr_q && wa_q == REG_CMD && hwdata[CMD_SW_TRIG] && !ctrl_q[CTRL_IN_AUTO];
    assign pwr_src = ctrl_q[CTRL_OUT_AUTO] && !run
        && (src == ETC_SRC_OUTPUT || src == ETC_SRC_ALL);
    // shadow of the bus-written configuration
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wr_q <= 1'b0;
            wa_q <= 8'h00;
            ctrl_q <= 13'h0000;
            trigv_q <= 16'h0000;
            trigf_q <= FSET_MIN_RESET;
            wid_q <= 1;
        end else begin
            wr_q <= hsel && hready && htrans[1] && hwrite;
            wa_q <= haddr[7:0];
            if (wr_q && wa_q == REG_CTRL) ctrl_q <= hwdata[12:0];
            if (wr_q && wa_q == REG_TRIGV) trigv_q <= hwdata[15:0];
            if (wr_q && wa_q == REG_TRIGF) trigf_q <= hwdata[15:0];
            if (wr_q && wa_q == REG_WIDTH) wid_q <= (hwdata < WIDTH_MIN_UNITS) ? WIDTH_MIN_UNITS
                : (hwdata > WIDTH_MAX_UNITS) ? WIDTH_MAX_UNITS : hwdata;
        end
    end
    // power change feeding the pulse restarts the width count
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            hi_q  <= 0;
            pwr_q <= 1'b0;
        end else begin
            pwr_q <= power_on;
            hi_q  <= (!trig_out || (power_on != pwr_q && pwr_src)) ? 0 : hi_q + 1;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    sequence s_pin_rise;
        !hsel ##1 ($rose(trig_in) && !hsel) ##1 !hsel [*3];
    endsequence
    a_auto_fire: assert property (
        s_pin_rise ##0 (ctrl_q[CTRL_IN_AUTO] && act == ETC_ACT_OUTPUT && !run)
        |-> power_on != $past(power_on, 3)) else $error("pin rise did not toggle power");
    a_cmd_toggle: assert property (
        fire && act == ETC_ACT_OUTPUT && !run |=> power_on != $past(power_on))
        else $error("command did not toggle power");
    a_set_apply: assert property (
        fire && act == ETC_ACT_SETTING && !run |=> volt_set == trigv_q && freq_set == trigf_q)
        else $error("triggered setpoints not applied");
    a_test_hold: assert property (
        fire && run && hwdata[5:1] == 5'h00 |=> $stable(power_on) && $stable(volt_set))
        else $error("action ran during test mode");
    a_trans_delay: assert property (
        fire && act == ETC_ACT_TRANS && !run |-> ##[D_LO:D_HI] transient_start)
        else $error("transient start not after delay");
    a_out_off: assert property (
        (!ctrl_q[CTRL_OUT_AUTO]) [*3] |-> !trig_out) else $error("trigger out high while off");
    a_out_follow: assert property (
        $changed(power_on) && ctrl_q[CTRL_OUT_AUTO] && !run
        && (src == ETC_SRC_OUTPUT || src == ETC_SRC_ALL) |-> ##[0:2] trig_out)
        else $error("power change gave no trigger out");
    a_pulse_width: assert property (
        $fell(trig_out) |-> hi_q + 1 >= wid_q * PULSE_UNIT_CYC
        && hi_q <= wid_q * PULSE_UNIT_CYC + 1) else $error("trigger out width wrong");
endmodule // etc_monitor
`default_nettype wire

/* File: verification/etc_top_tb.sv */
// self-checking bench for etc_top
// assumes etc_equip and etc_monitor are compiled first
`timescale 1ns/1ns
`default_nettype none
module etc_top_tb;
    import etc_pkg::*;
    localparam int unsigned DLY = 20;
    localparam int unsigned PU  = 4;
    logic        clk_sys, arst_n, hsel, hwrite, hreadyout, hresp, rd_pend;
    logic        trig_in, trig_out, power_on, transient_start;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [15:0] volt_set, freq_set, rv, rf;
    logic [31:0] exp_q[$];
    int          fail_count, n_compared, n_pulses, last_width, seed, t;
    etc_top #(.DELAY_CYC(DLY), .PULSE_UNIT_CYC(PU)) DUT (
        .clk_sys, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .trig_in, .trig_out,
        .power_on, .volt_set, .freq_set, .transient_start);
    etc_equip EQ (.clk_sys, .trig_out, .trig_in, .n_pulses, .last_width);
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        summarize();
    end
    task automatic cmp_reg(input logic [31:0] e, input logic [31:0] a);
        n_compared++;
        if (a !== e) begin
            fail_count++;
            $display("[FAIL] %0t exp %h got %h", $time, e, a);
        end
    endtask
    task automatic cmp_val(input logic [31:0] e, input logic [31:0] a);
        cmp_reg(e, a);
    endtask
    // read data checked against the oldest note
    always @(posedge clk_sys) begin
        if (rd_pend && hreadyout === 1'b1) begin
            cmp_reg(exp_q.pop_front(), hrdata);
            cmp_reg(32'h0, {31'h0, hresp});
        end
        rd_pend <= hsel && htrans[1] && !hwrite && hreadyout;
    end
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            fail_count++;
            summarize();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'b10;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic settle;
        repeat (12) @(posedge clk_sys);
    endtask
    initial begin
        arst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        rd_pend = 1'b0;
        fail_count = 0;
        n_compared = 0;
        seed = 20;
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd(REG_CTRL, 32'h0);
        rd(REG_TRIGF, 32'h1194);
        wr(8'h40, 32'hffffffff);
        rd(8'h40, 32'h0);
        $display("test reset done");
        wr(REG_CTRL, 32'h2);
        EQ.strike(3);
        rd(REG_STATUS, 32'h0);
        wr(REG_CMD, 32'h1);
        rd(REG_STATUS, 32'h1);
        $display("test manual done");
        wr(REG_WIDTH, 32'h0);
        rd(REG_WIDTH, 32'h1);
        wr(REG_WIDTH, 32'h7d0);
        rd(REG_WIDTH, 32'h3e8);
        wr(REG_WIDTH, 32'h2);
        wr(REG_CTRL, 32'h303);
        EQ.strike(6);
        settle();
        rd(REG_STATUS, 32'h0);
        cmp_val(32'h1, n_pulses);
        cmp_val(32'h1, last_width inside {[2*PU-1:2*PU+1]});
        wr(REG_CTRL, 32'h102);
        wr(REG_CMD, 32'h1);
        wr(REG_CTRL, 32'h202);
        wr(REG_CMD, 32'h1);
        settle();
        cmp_val(32'h1, n_pulses);
        $display("test output pin done");
        rv = 16'($random(seed)) | 16'h0001;
        rf = 16'h1195 + {5'h00, 11'($random(seed))};
        wr(REG_TRIGV, {16'h0000, rv});
        wr(REG_TRIGF, {16'h0000, rf});
        wr(REG_CTRL, 32'h504);
        wr(REG_CMD, 32'h1);
        rd(REG_SETV, {16'h0000, rv});
        rd(REG_SETF, {16'h0000, rf});
        settle();
        cmp_val(32'h2, n_pulses);
        $display("test setting done");
        wr(REG_CMD, 32'h302);
        rd(REG_STATUS, 32'h80000);
        wr(REG_CTRL, 32'h736);
        wr(REG_SETV, 32'h55);
        wr(REG_CMD, 32'h1);
        rd(REG_SETV, {16'h0000, rv});
        settle();
        cmp_val(32'h3, n_pulses);
        wr(REG_CMD, 32'ha02);
        wr(REG_CMD, 32'h308);
        rd(REG_STATUS, 32'h0);
        wr(REG_SETV, 32'h55);
        wr(REG_CMD, 32'h304);
        rd(REG_SETV, 32'h55);
        $display("test slots done");
        wr(REG_CTRL, 32'h902);
        wr(REG_CMD, 32'h1);
        settle();
        cmp_val(32'h4, n_pulses);
        wr(REG_CMD, 32'h1);
        wr(REG_CMD, 32'h1);
        settle();
        cmp_val(32'h5, n_pulses);
        cmp_val(32'h1, last_width > 2*PU+1);
        wr(REG_CMD, 32'h10);
        settle();
        cmp_val(32'h6, n_pulses);
        wr(REG_CTRL, 32'h1002);
        wr(REG_CMD, 32'h1);
        rd(REG_STATUS, 32'h0);
        $display("test all and test mode done");
        wr(REG_CTRL, 32'h8);
        wr(REG_CMD, 32'h1);
        t = 0;
        while (transient_start !== 1'b1 && t < 100) begin
            @(posedge clk_sys);
            t++;
        end
        cmp_val(32'h1, t inside {[DLY-2:DLY+4]});
        $display("test transient done");
        summarize();
    end
endmodule // etc_top_tb
bind etc_top etc_monitor #(.DELAY_CYC(DELAY_CYC), .PULSE_UNIT_CYC(PULSE_UNIT_CYC)) MON (
    .clk_sys, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .trig_in,
    .trig_out, .power_on, .volt_set, .freq_set, .transient_start);
`default_nettype wire

/* File: verilog/etc_pulse_gen.sv */
// trigger output pulse stretcher
// assumes synchronous one-cycle event input
`timescale 1ns/1ns
`default_nettype none
module etc_pulse_gen #(
    parameter int unsigned UNIT_CYC  = 1000,
    parameter int unsigned WIDTH_W   = 10
) (
    input  wire logic               clk_sys,
    input  wire logic               arst_n,
    input  wire logic               event_i,
    input  wire logic [WIDTH_W-1:0] width_units,
    output logic                    pulse_o
);
    localparam int CW = $clog2(UNIT_CYC + 1);
    logic [CW-1:0]      sub_q;
    logic [WIDTH_W-1:0] units_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sub_q   <= '0;
            units_q <= '0;
            pulse_o <= 1'b0;
        end else if (event_i) begin
            sub_q   <= CW'(UNIT_CYC - 1);
            units_q <= width_units;
            pulse_o <= 1'b1;
        end else if (pulse_o) begin
            if (sub_q != '0) begin
                sub_q <= sub_q - 1'b1;
            end else if (units_q <= WIDTH_W'(1)) begin
                units_q <= '0;
                pulse_o <= 1'b0;
            end else begin
                units_q <= units_q - 1'b1;
                sub_q   <= CW'(UNIT_CYC - 1);
            end
        end
    end
endmodule // etc_pulse_gen
`default_nettype wire

/* File: verilog/etc_top.sv */
// external trigger controller with ten configuration slots
// assumes AHB-Lite single word transfers, asynchronous trigger input
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - auto input mode fires the action on each rising trigger input
// - manual input mode ignores the pin, fires on software trigger only
// - action none does nothing; action output toggles power output
// - setting action applies stored triggered voltage and frequency
// - preset action loads slot chosen by slot index, one of ten
// - transient action starts the surge or dip event
// - auto output mode drives trigger out on events; off holds low
// - source none never asserts trigger out
// - source output asserts trigger out on power on or off
// - source setting asserts trigger out on voltage or frequency change
// - source preset asserts trigger out on slot load or save
// - source all asserts on settings, slot, or output change
// - trigger out pulse width programmable 0.1 to 100.0 ms
// - test modes running disable input action and output source
// - ten slots store present settings and restore them
// - a selected slot can be cleared, no longer holding settings
// - transient starts after fixed 100 ms delay
module etc_top
    import etc_pkg::*;
#(
    parameter int unsigned DELAY_CYC = TRANS_DELAY_CYC,
    parameter int unsigned PULSE_UNIT_CYC = UNIT_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        trig_in,
    output logic             trig_out,
    output logic             power_on,
    output logic      [15:0] volt_set,
    output logic      [15:0] freq_set,
    output logic             transient_start
);
    localparam int SW = $clog2(NUM_SLOTS);

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic       wr_pend_q;
    logic [7:0] addr_q;
    logic       take;
    logic       wr_now;

    assign take   = hsel && hready && htrans[1];
    assign wr_now = wr_pend_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wr_pend_q <= 1'b0;
            addr_q    <= '0;
        end else begin
            wr_pend_q <= take && hwrite;
            if (take) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic [12:0] ctrl_q;
    logic [15:0] trig_v_q;
    logic [15:0] trig_f_q;
    logic [9:0]  width_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q   <= '0;
            trig_v_q <= '0;
            trig_f_q <= FSET_MIN_RESET;
            width_q  <= 10'(WIDTH_MIN_UNITS);
        end else if (wr_now) begin
            unique case (addr_q)
                REG_CTRL:  ctrl_q   <= hwdata[12:0];
                REG_TRIGV: trig_v_q <= hwdata[15:0];
                REG_TRIGF: trig_f_q <= hwdata[15:0];
                REG_WIDTH: begin
                    if (hwdata[15:0] < 16'(WIDTH_MIN_UNITS)) begin
                        width_q <= 10'(WIDTH_MIN_UNITS);
                    end else if (hwdata[15:0] > 16'(WIDTH_MAX_UNITS)) begin
                        width_q <= 10'(WIDTH_MAX_UNITS);
                    end else begin
                        width_q <= hwdata[9:0];
                    end
                end
                default: ;
            endcase
        end
    end

    logic        in_auto;
    logic        out_auto;
    logic        test_run;
    etc_action_e action;
    etc_source_e source;
    logic [3:0]  trig_slot;

    assign in_auto   = ctrl_q[CTRL_IN_AUTO];
    assign out_auto  = ctrl_q[CTRL_OUT_AUTO];
    assign test_run  = ctrl_q[CTRL_TEST_RUN];
    assign action    = etc_action_e'(ctrl_q[CTRL_ACT_LSB +: 3]);
    assign source    = etc_source_e'(ctrl_q[CTRL_SRC_LSB +: 3]);
    assign trig_slot = ctrl_q[CTRL_SLOT_LSB +: 4];

    // command decode, one-cycle pulses
    logic       cmd_wr;
    logic       sw_trig;
    logic       cmd_save;
    logic       cmd_load;
    logic       cmd_clear;
    logic       cmd_pwr;
    logic [3:0] cmd_slot;

    assign cmd_wr    = wr_now && (addr_q == REG_CMD);
    assign sw_trig   = cmd_wr && hwdata[CMD_SW_TRIG];
    assign cmd_save  = cmd_wr && hwdata[CMD_SAVE];
    assign cmd_load  = cmd_wr && hwdata[CMD_LOAD];
    assign cmd_clear = cmd_wr && hwdata[CMD_CLEAR];
    assign cmd_pwr   = cmd_wr && hwdata[CMD_PWR];
    assign cmd_slot  = hwdata[CMD_SLOT_LSB +: 4];

    // ------------------------------------------------------------
    // trigger input
    // ------------------------------------------------------------
    logic sync1_q;
    logic sync2_q;
    logic sync3_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end else begin
            sync1_q <= trig_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    logic fire;
    assign fire = !test_run && (in_auto ? (sync2_q && !sync3_q) : sw_trig);

    logic fire_out;
    logic fire_set;
    logic fire_pre;
    logic fire_trn;
    assign fire_out = fire && (action == ETC_ACT_OUTPUT);
    assign fire_set = fire && (action == ETC_ACT_SETTING);
    assign fire_pre = fire && (action == ETC_ACT_PRESET) && (trig_slot < 4'(NUM_SLOTS));
    assign fire_trn = fire && (action == ETC_ACT_TRANS);

    // ------------------------------------------------------------
    // slots and present settings
    // ------------------------------------------------------------
    logic [31:0]          slot_mem [NUM_SLOTS];
    logic [NUM_SLOTS-1:0] slot_valid_q;
    logic                 do_load;
    logic [3:0]           load_slot;
    logic                 load_ok;
    logic                 save_ok;

    assign load_slot = fire_pre ? trig_slot : cmd_slot;
    assign do_load   = fire_pre || (cmd_load && cmd_slot < 4'(NUM_SLOTS));
    assign load_ok   = do_load && slot_valid_q[load_slot[SW-1:0]];
    assign save_ok   = cmd_save && cmd_slot < 4'(NUM_SLOTS);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            slot_valid_q <= '0;
        end else if (save_ok) begin
            slot_valid_q[cmd_slot[SW-1:0]] <= 1'b1;
        end else if (cmd_clear && cmd_slot < 4'(NUM_SLOTS)) begin
            slot_valid_q[cmd_slot[SW-1:0]] <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (save_ok) begin
            slot_mem[cmd_slot[SW-1:0]] <= {freq_set, volt_set};
        end
    end

    logic [15:0] v_d;
    logic [15:0] f_d;
    logic        set_chg;

    always_comb begin
        v_d = volt_set;
        f_d = freq_set;
        if (wr_now && addr_q == REG_SETV) begin
            v_d = hwdata[15:0];
        end
        if (wr_now && addr_q == REG_SETF) begin
            f_d = hwdata[15:0];
        end
        if (load_ok) begin
            v_d = slot_mem[load_slot[SW-1:0]][15:0];
            f_d = slot_mem[load_slot[SW-1:0]][31:16];
        end
        if (fire_set) begin
            v_d = trig_v_q;
            f_d = trig_f_q;
        end
    end
    assign set_chg = (v_d != volt_set) || (f_d != freq_set);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            volt_set <= '0;
            freq_set <= FSET_MIN_RESET;
        end else begin
            volt_set <= v_d;
            freq_set <= f_d;
        end
    end

    logic pwr_d;
    always_comb begin
        pwr_d = power_on;
        if (cmd_pwr) begin
            pwr_d = hwdata[CMD_PWR_VAL];
        end
        if (fire_out) begin
            pwr_d = !power_on;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            power_on <= 1'b0;
        end else begin
            power_on <= pwr_d;
        end
    end

    // ------------------------------------------------------------
    // transient delay
    // ------------------------------------------------------------
    localparam int DW = $clog2(DELAY_CYC + 1);
    logic [DW-1:0] dly_q;
    logic          dly_run_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dly_q           <= '0;
            dly_run_q       <= 1'b0;
            transient_start <= 1'b0;
        end else begin
            transient_start <= 1'b0;
            if (fire_trn && !dly_run_q) begin
                dly_run_q <= 1'b1;
                dly_q     <= DW'(DELAY_CYC - 1);
            end else if (dly_run_q) begin
                if (dly_q == '0) begin
                    dly_run_q       <= 1'b0;
                    transient_start <= 1'b1;
                end else begin
                    dly_q <= dly_q - 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // trigger output
    // ------------------------------------------------------------
    logic ev_out;
    logic ev_set;
    logic ev_pre;
    logic out_ev;

    assign ev_out = pwr_d != power_on;
    assign ev_set = set_chg;
    assign ev_pre = load_ok || save_ok;

    always_comb begin
        out_ev = 1'b0;
        unique case (source)
            ETC_SRC_OUTPUT:  out_ev = ev_out;
            ETC_SRC_SETTING: out_ev = ev_set;
            ETC_SRC_PRESET:  out_ev = ev_pre;
            ETC_SRC_ALL:     out_ev = ev_out || ev_set || ev_pre;
            default:         out_ev = 1'b0;
        endcase
        out_ev = out_ev && out_auto && !test_run;
    end

    logic pulse;
    etc_pulse_gen #(
        .UNIT_CYC (PULSE_UNIT_CYC),
        .WIDTH_W  (10)
    ) u_pulse (
        .clk_sys     (clk_sys),
        .arst_n      (arst_n),
        .event_i     (out_ev),
        .width_units (width_q),
        .pulse_o     (pulse)
    );

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            trig_out <= 1'b0;
        end else begin
            trig_out <= pulse && out_auto;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            hrdata <= '0;
        end else if (take && !hwrite) begin
            unique case (haddr[7:0])
                REG_CTRL:   hrdata <= {19'h0, ctrl_q};
                REG_TRIGV:  hrdata <= {16'h0, trig_v_q};
                REG_TRIGF:  hrdata <= {16'h0, trig_f_q};
                REG_WIDTH:  hrdata <= {22'h0, width_q};
                REG_SETV:   hrdata <= {16'h0, volt_set};
                REG_SETF:   hrdata <= {16'h0, freq_set};
                REG_STATUS: hrdata <= {6'h0, slot_valid_q, 13'h0,
                                       dly_run_q, trig_out, power_on};
                default:    hrdata <= '0;
            endcase
        end
    end
endmodule // etc_top
`default_nettype wire
